// ===== bench/cbc_far_side.sv
`timescale 1ns/100ps

// Memory and ports answer at once from a fixed pattern; acknowledge gets a vector.
module cbc_far_side #(
    parameter logic [7:0] VEC = 8'hC4
) (
    input wire logic pclk,
    input wire logic [15:0] address_out,
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    input wire logic rd_n,
    input wire logic port_request_n,
    input wire logic opcode_fetch_cycle_n,
    output logic [7:0] data_in
);
    logic [7:0] last = 8'h00;
    // A floating bus shows the inverse of its last level so stale data cannot pass.
    assign data_in = data_oe ? data_out :
        (!port_request_n && !opcode_fetch_cycle_n) ? VEC :
        !rd_n ? (address_out[7:0] ^ 8'h5A) : ~last;
    always @(posedge pclk) begin
        last <= data_in;
    end
endmodule

// ===== bench/test_cpu_bus_control_interface.sv
`timescale 1ns/100ps

module test_cpu_bus_control_interface;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic wait_n = 1, int_n = 1, nmi_n = 1, bus_takeover_request_n = 1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd_q;
    logic [15:0] address_out;
    logic [7:0] data_out, data_in;
    logic [3:0] saw = 4'h0;
    logic pready, pslverr, err_q, addr_oe, data_oe, ctrl_oe, opcode_fetch_cycle_n;
    logic memory_access_request_n, port_request_n, rd_n, wr_n, refresh_cycle_n, halt_n;
    logic bus_released_n;
    int n_errors = 0, tests_run = 0, cyc = 0;

    cbc_bus_ctrl cbc_bus_ctrl_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .address_out, .addr_oe, .data_out, .data_oe,
        .data_in, .ctrl_oe, .opcode_fetch_cycle_n, .memory_access_request_n, .port_request_n,
        .rd_n, .wr_n, .refresh_cycle_n, .halt_n, .bus_released_n, .wait_n, .int_n, .nmi_n,
        .bus_takeover_request_n);
    cbc_far_side cbc_far_side_inst (.pclk, .address_out, .data_out, .data_oe, .rd_n,
        .port_request_n, .opcode_fetch_cycle_n, .data_in);

    always #5 pclk = ~pclk;

    task give_verdict;
        if (n_errors == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp, input string name);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            give_verdict;
        end
        if (presetn) begin
            saw <= saw | {~refresh_cycle_n, ~opcode_fetch_cycle_n, ~port_request_n, ~wr_n};
            if (!refresh_cycle_n) chk(32'(memory_access_request_n), 0, "refresh_cycle memory_access_request");
            if (!port_request_n && opcode_fetch_cycle_n) chk(32'(address_out[15:8]), 0, "port hi");
            if (!wr_n) chk(32'(data_oe), 1, "write data");
            if (!bus_released_n) chk(32'({addr_oe, data_oe, ctrl_oe}), 0, "floated");
        end
    end

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Two quiet reads in a row are needed: the single idle cycle between
    // machine cycles must not pass for the end of a chain.
    task wait_idle;
        int quiet;
        quiet = 0;
        for (int i = 0; i < 50 && quiet < 2; i++) begin
            apb(1'b0, 12'h00C, 32'h0);
            quiet = (rd_q[0] === 1'b0 && rd_q[3] === 1'b0) ? quiet + 1 : 0;
        end
        if (quiet < 2) chk(32'(quiet), 2, "idle");
    endtask

    task op(input logic [3:0] cmd, input logic [15:0] a);
        apb(1'b1, 12'h004, {16'h0, a});
        apb(1'b1, 12'h008, 32'h0000_003C);
        apb(1'b1, 12'h000, {28'h0, cmd});
        wait_idle;
    endtask

    task t_reset;
        apb(1'b0, 12'h014, 32'h0);
        chk(rd_q, 32'h0, "irm reset");
        apb(1'b0, 12'h010, 32'h0);
        chk(32'(rd_q[15:0]), 32'h0, "pc reset");
        apb(1'b0, 12'hFF0, 32'h0);
        chk(32'(err_q), 1, "unmapped");
        apb(1'b1, 12'h040, 32'h11);
        op(4'h7, 16'h0000);
        apb(1'b1, 12'h040, 32'h22);
        op(4'h7, 16'h0000);
        apb(1'b0, 12'h040, 32'h0);
        chk(rd_q, 32'h11, "bank swap");
    endtask

    task t_cycles;
        for (int k = 0; k < 5; k++) begin
            op(k[3:0], 16'hA5C3);
            if (k == 1 || k == 3) chk(32'(rd_q[15:8]), 32'(8'hC3 ^ 8'h5A), "read byte");
        end
        chk(32'(saw), 32'hF, "strobes seen");
        wait_n <= 1'b0;
        apb(1'b1, 12'h000, 32'h1);
        repeat (20) @(posedge pclk);
        chk(32'({memory_access_request_n, rd_n, refresh_cycle_n}), 1, "wait held");
        wait_n <= 1'b1;
        wait_idle;
    endtask

    task t_int;
        apb(1'b1, 12'h014, 32'h0100_0000);
        int_n <= 1'b0;
        op(4'h8, 16'h0000);
        wait_idle;
        int_n <= 1'b1;
        chk(32'(rd_q[23:16]), 32'hC4, "vector");
        apb(1'b0, 12'h014, 32'h0);
        chk(32'(rd_q[24]), 0, "enable cleared");
    endtask

    task t_halt_nmi;
        apb(1'b1, 12'h000, 32'h6);
        repeat (4) @(posedge pclk);
        chk(32'(halt_n), 0, "halt out");
        nmi_n <= 1'b0;
        wait_idle;
        wait_idle;
        nmi_n <= 1'b1;
        chk(32'(halt_n), 1, "halt exit");
        apb(1'b0, 12'h010, 32'h0);
        chk(32'(rd_q[15:0]), 32'h0066, "nmi restart");
    endtask

    task t_takeover;
        apb(1'b1, 12'h000, 32'h2);
        bus_takeover_request_n <= 1'b0;
        for (int i = 0; i < 30 && bus_released_n !== 1'b0; i++) @(posedge pclk);
        chk(32'({bus_released_n, addr_oe}), 0, "takeover");
        bus_takeover_request_n <= 1'b1;
        for (int i = 0; i < 30 && bus_released_n !== 1'b1; i++) @(posedge pclk);
        chk(32'(bus_released_n), 1, "bus back");
    endtask

    initial begin
        repeat (15) @(posedge pclk);
        chk(32'({addr_oe, data_oe, halt_n, rd_n, wr_n}), 32'h7, "reset pins");
        @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_cycles;
        t_int;
        t_halt_nmi;
        t_takeover;
        give_verdict;
    end
endmodule

// ===== rtl/cbc_bus_ctrl.sv
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`include "cbc_consts.svh"

// Operation
// - Drive sixteen address lines, bit zero least.
// - Port number only on low eight lines.
// - Refresh address on low seven, with strobes.
// - Eight-bit two-way data bus.
// - Opcode fetch indicator on every opcode fetch.
// - Acknowledge shows fetch indicator plus port request.
// - Memory request only with valid address.
// - Port request with valid low port address.
// - Interrupting device supplies vector on acknowledge.
// - Read strobe while data can be accepted.
// - Write strobe only while data driven.
// - Halt output, keep refreshing until interrupt.
// - Stay waiting while wait held; no refresh.
// - Maskable accepted at boundary, enabled, no takeover.
// - Non-maskable on leading edge, ignores enable.
// - Non-maskable pushes counter, restarts fixed address.
// - Wait holds off non-maskable; takeover outranks.
// - Reset clears counter, enable, page, refresh, mode.
// - Reset floats buses, controls held inactive.
// - Takeover request floats buses at cycle end.
// - Bus released output while buses floated.
// - Two register banks swapped by exchange.
module cbc_bus_ctrl (
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [15:0] address_out,
    output logic addr_oe,
    output logic [7:0] data_out,
    output logic data_oe,
    input logic [7:0] data_in,
    output logic ctrl_oe,
    output logic opcode_fetch_cycle_n,
    output logic memory_access_request_n,
    output logic port_request_n,
    output logic rd_n,
    output logic wr_n,
    output logic refresh_cycle_n,
    output logic halt_n,
    output logic bus_released_n,
    input logic wait_n,
    input logic int_n,
    input logic nmi_n,
    input logic bus_takeover_request_n
);
    import cbc_pkg::*;

    function automatic logic is_m1kind(input cbc_kind_t k);
        is_m1kind = (k == K_FETCH) || (k == K_HALT) || (k == K_INTA);
    endfunction

    function automatic logic in_bank(input logic [11:0] a);
        in_bank = (a >= `CBC_OFF_BANK_LO) && (a <= `CBC_OFF_BANK_HI) && (a[1:0] == 2'h0);
    endfunction

    cbc_state_t st_reg, st_next;
    cbc_kind_t kind_reg, kind_next, cmd_kind_reg;
    logic [15:0] cyc_addr_reg, cyc_addr_next, pc_reg, sp_reg, addr_reg;
    logic [7:0] cyc_data_reg, cyc_data_next, wdata_reg, ireg_reg, rdata_reg, vector_reg;
    logic [6:0] rcnt_reg;
    logic [1:0] im_reg, nmi_step_reg, cap_sr;
    logic ie_reg, bank_reg, halted_reg, at_bound_reg, nmi_pend_reg, run_last_reg;
    logic cmd_pend_reg, cmd_last_reg, cap_inta_reg;
    logic go_push, go_nmi, go_int, go_nop, go_cmd, mc_last;
    logic [1:0] wait_sr, int_sr, nmi_sr, bus_takeover_request_sr;
    logic [7:0] data_s1, data_s2;
    logic nmi_prev_reg, nmi_edge, wait_lo, int_lo, bus_takeover_request_lo;
    logic acc, wr_fire, hit, busy;
    logic [31:0] rd_mux;
    logic [7:0] bank_rdata;
    logic [15:0] addr_nx;
    logic [7:0] data_nx;
    logic addr_oe_nx, data_oe_nx, ctrl_oe_nx, m1_nx, memory_access_request_nx, port_request_nx, rd_nx, wr_nx, refresh_cycle_nx;

    // Pins from outside the clock domain pass two flops before use.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_sr <= 2'h3;
            int_sr <= 2'h3;
            nmi_sr <= 2'h3;
            bus_takeover_request_sr <= 2'h3;
            data_s1 <= 8'h00;
            data_s2 <= 8'h00;
            nmi_prev_reg <= 1'b1;
        end else begin
            wait_sr <= {wait_sr[0], wait_n};
            int_sr <= {int_sr[0], int_n};
            nmi_sr <= {nmi_sr[0], nmi_n};
            bus_takeover_request_sr <= {bus_takeover_request_sr[0], bus_takeover_request_n};
            data_s1 <= data_in;
            data_s2 <= data_s1;
            nmi_prev_reg <= nmi_sr[1];
        end
    end

    assign wait_lo = !wait_sr[1];
    assign int_lo = !int_sr[1];
    assign bus_takeover_request_lo = !bus_takeover_request_sr[1];
    assign nmi_edge = nmi_prev_reg && !nmi_sr[1];
    assign mc_last = (st_reg == ST_T4) || ((st_reg == ST_T3) && !is_m1kind(kind_reg));

    // Dispatch happens only from idle, so every machine cycle is followed by one idle
    // cycle; that costs bandwidth but keeps all priority decisions in one place.
    always_comb begin
        st_next = st_reg;
        kind_next = kind_reg;
        cyc_addr_next = cyc_addr_reg;
        cyc_data_next = cyc_data_reg;
        go_push = 1'b0;
        go_nmi = 1'b0;
        go_int = 1'b0;
        go_nop = 1'b0;
        go_cmd = 1'b0;
        case (st_reg)
            ST_IDLE: begin
                if (bus_takeover_request_lo) begin
                    st_next = ST_REL;
                end else if (nmi_step_reg == `CBC_STEP_SECOND) begin
                    go_push = 1'b1;
                end else if (at_bound_reg && nmi_pend_reg) begin
                    go_nmi = 1'b1;
                end else if (at_bound_reg && int_lo && ie_reg) begin
                    go_int = 1'b1;
                end else if (halted_reg) begin
                    go_nop = 1'b1;
                end else if (cmd_pend_reg) begin
                    go_cmd = 1'b1;
                end
                if (go_push || go_nmi) begin
                    st_next = ST_T1;
                    kind_next = K_MWR;
                    cyc_addr_next = go_nmi ? sp_reg - 16'h0001 : sp_reg - 16'h0002;
                    cyc_data_next = go_nmi ? pc_reg[15:8] : pc_reg[7:0];
                end else if (go_int || go_nop) begin
                    st_next = ST_T1;
                    kind_next = go_int ? K_INTA : K_HALT;
                    cyc_addr_next = pc_reg;
                end else if (go_cmd && cmd_kind_reg != K_EXX && cmd_kind_reg != K_HALT) begin
                    st_next = ST_T1;
                    cyc_data_next = wdata_reg;
                    if (cmd_kind_reg == K_FETCH || cmd_kind_reg == K_INTA) begin
                        kind_next = K_FETCH;
                        cyc_addr_next = pc_reg;
                    end else if (cmd_kind_reg == K_PRD || cmd_kind_reg == K_PWR) begin
                        kind_next = cmd_kind_reg;
                        cyc_addr_next = {`CBC_PORT_HIGH, addr_reg[7:0]};
                    end else begin
                        kind_next = cmd_kind_reg;
                        cyc_addr_next = addr_reg;
                    end
                end
            end
            ST_T1: st_next = ST_T2;
            ST_T2: st_next = ST_TW;
            ST_TW: begin
                if (!wait_lo) begin
                    st_next = ST_T3;
                end
            end
            ST_T3: begin
                if (is_m1kind(kind_reg)) begin
                    st_next = ST_T4;
                end else begin
                    st_next = bus_takeover_request_lo ? ST_REL : ST_IDLE;
                end
            end
            ST_T4: st_next = bus_takeover_request_lo ? ST_REL : ST_IDLE;
            ST_REL: begin
                if (!bus_takeover_request_lo) begin
                    st_next = ST_IDLE;
                end
            end
            default: st_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= ST_IDLE;
            kind_reg <= K_FETCH;
            cyc_addr_reg <= 16'h0000;
            cyc_data_reg <= 8'h00;
        end else begin
            st_reg <= st_next;
            kind_reg <= kind_next;
            cyc_addr_reg <= cyc_addr_next;
            cyc_data_reg <= cyc_data_next;
        end
    end

    // Pin values are worked out from the next state so they leave flops aligned with it.
    always_comb begin
        addr_nx = cyc_addr_next;
        data_nx = cyc_data_next;
        addr_oe_nx = 1'b0;
        data_oe_nx = 1'b0;
        ctrl_oe_nx = 1'b1;
        m1_nx = 1'b1;
        memory_access_request_nx = 1'b1;
        port_request_nx = 1'b1;
        rd_nx = 1'b1;
        wr_nx = 1'b1;
        refresh_cycle_nx = 1'b1;
        case (st_next)
            ST_T1, ST_T2, ST_TW: begin
                addr_oe_nx = 1'b1;
                m1_nx = !is_m1kind(kind_next);
                if (kind_next == K_FETCH || kind_next == K_HALT || kind_next == K_MRD
                        || kind_next == K_MWR) begin
                    memory_access_request_nx = 1'b0;
                end
                if (kind_next == K_FETCH || kind_next == K_HALT || kind_next == K_MRD) begin
                    rd_nx = 1'b0;
                end
                data_oe_nx = (kind_next == K_MWR) || (kind_next == K_PWR);
                if (st_next != ST_T1) begin
                    wr_nx = !data_oe_nx;
                    if (kind_next == K_PRD || kind_next == K_PWR || kind_next == K_INTA) begin
                        port_request_nx = 1'b0;
                    end
                    if (kind_next == K_PRD) begin
                        rd_nx = 1'b0;
                    end
                end
            end
            ST_T3, ST_T4: begin
                addr_oe_nx = 1'b1;
                if (is_m1kind(kind_next)) begin
                    addr_nx = {ireg_reg, 1'b0, rcnt_reg};
                    memory_access_request_nx = 1'b0;
                    refresh_cycle_nx = 1'b0;
                end else begin
                    data_oe_nx = (kind_next == K_MWR) || (kind_next == K_PWR);
                end
            end
            ST_REL: ctrl_oe_nx = 1'b0;
            default: ctrl_oe_nx = 1'b1;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            address_out <= 16'h0000;
            addr_oe <= 1'b0;
            data_out <= 8'h00;
            data_oe <= 1'b0;
            ctrl_oe <= 1'b1;
            opcode_fetch_cycle_n <= 1'b1;
            memory_access_request_n <= 1'b1;
            port_request_n <= 1'b1;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            refresh_cycle_n <= 1'b1;
            halt_n <= 1'b1;
            bus_released_n <= 1'b1;
        end else begin
            address_out <= addr_nx;
            addr_oe <= addr_oe_nx;
            data_out <= data_nx;
            data_oe <= data_oe_nx;
            ctrl_oe <= ctrl_oe_nx;
            opcode_fetch_cycle_n <= m1_nx;
            memory_access_request_n <= memory_access_request_nx;
            port_request_n <= port_request_nx;
            rd_n <= rd_nx;
            wr_n <= wr_nx;
            refresh_cycle_n <= refresh_cycle_nx;
            halt_n <= !halted_reg;
            bus_released_n <= (st_next != ST_REL);
        end
    end

    // Set wins over clear, so an edge in the acceptance cycle is kept for later.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nmi_pend_reg <= 1'b0;
        end else if (nmi_edge) begin
            nmi_pend_reg <= 1'b1;
        end else if (go_nmi) begin
            nmi_pend_reg <= 1'b0;
        end
    end

    // Read data passes the pin synchroniser, so it is taken two edges after the strobe.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_sr <= 2'h0;
            cap_inta_reg <= 1'b0;
            rdata_reg <= 8'h00;
            vector_reg <= 8'h00;
        end else begin
            cap_sr <= {cap_sr[0], (st_reg == ST_TW) && !wait_lo && !data_oe};
            if (st_reg == ST_TW) begin
                cap_inta_reg <= (kind_reg == K_INTA);
            end
            if (cap_sr[1]) begin
                rdata_reg <= data_s2;
                if (cap_inta_reg) begin
                    vector_reg <= data_s2;
                end
            end
        end
    end

    assign acc = psel && penable;
    assign wr_fire = acc && pready && pwrite;
    assign busy = cmd_pend_reg || (st_reg != ST_IDLE) || (cap_sr != 2'h0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_reg <= `CBC_PC_RESET;
            sp_reg <= `CBC_SP_RESET;
            ireg_reg <= `CBC_IREG_RESET;
            rcnt_reg <= `CBC_RCNT_RESET;
            im_reg <= `CBC_IM_RESET;
            ie_reg <= 1'b0;
            bank_reg <= 1'b0;
            halted_reg <= 1'b0;
            at_bound_reg <= 1'b1;
            nmi_step_reg <= 2'h0;
            run_last_reg <= 1'b0;
            cmd_pend_reg <= 1'b0;
            cmd_kind_reg <= K_FETCH;
            cmd_last_reg <= 1'b0;
            addr_reg <= 16'h0000;
            wdata_reg <= 8'h00;
        end else begin
            if (wr_fire) begin
                if (paddr == `CBC_OFF_CMD) begin
                    if (!cmd_pend_reg) begin
                        cmd_pend_reg <= 1'b1;
                        cmd_kind_reg <= cbc_kind_t'(pwdata[`CBC_CMD_KIND]);
                        cmd_last_reg <= pwdata[`CBC_CMD_LAST];
                    end
                end else if (paddr == `CBC_OFF_ADDR) begin
                    addr_reg <= pwdata[`CBC_ADDR_F];
                end else if (paddr == `CBC_OFF_WDATA) begin
                    wdata_reg <= pwdata[`CBC_WDATA_F];
                end else if (paddr == `CBC_OFF_PCSP) begin
                    pc_reg <= pwdata[`CBC_PCSP_PC];
                    sp_reg <= pwdata[`CBC_PCSP_SP];
                end else if (paddr == `CBC_OFF_IRM) begin
                    ireg_reg <= pwdata[`CBC_IRM_I];
                    rcnt_reg <= pwdata[`CBC_IRM_R];
                    im_reg <= pwdata[`CBC_IRM_IM];
                    ie_reg <= pwdata[`CBC_IRM_IE];
                end
            end
            if (go_cmd) begin
                cmd_pend_reg <= 1'b0;
                run_last_reg <= cmd_last_reg;
                at_bound_reg <= 1'b0;
                if (cmd_kind_reg == K_EXX) begin
                    bank_reg <= !bank_reg;
                    at_bound_reg <= cmd_last_reg;
                end else if (cmd_kind_reg == K_HALT) begin
                    halted_reg <= 1'b1;
                    at_bound_reg <= 1'b1;
                end else if (cmd_kind_reg == K_FETCH || cmd_kind_reg == K_INTA) begin
                    pc_reg <= pc_reg + 16'h0001;
                end
            end
            if (go_int || go_nmi) begin
                ie_reg <= 1'b0;
                halted_reg <= 1'b0;
                at_bound_reg <= 1'b0;
                run_last_reg <= 1'b1;
            end
            if (go_nmi) begin
                nmi_step_reg <= `CBC_STEP_FIRST;
            end
            if (go_push) begin
                nmi_step_reg <= `CBC_STEP_RUN2;
            end
            if (mc_last) begin
                if (is_m1kind(kind_reg)) begin
                    rcnt_reg <= rcnt_reg + 7'h01;
                end
                if (nmi_step_reg == `CBC_STEP_FIRST) begin
                    nmi_step_reg <= `CBC_STEP_SECOND;
                end else if (nmi_step_reg == `CBC_STEP_RUN2) begin
                    pc_reg <= `CBC_NMI_ADDR;
                    sp_reg <= sp_reg - 16'h0002;
                    nmi_step_reg <= 2'h0;
                    at_bound_reg <= 1'b1;
                end else if (run_last_reg) begin
                    at_bound_reg <= 1'b1;
                end
            end
        end
    end

    cbc_regbank #(.WIDTH(8), .DEPTH(16), .AW(4)) u_bank (
        .clk(pclk),
        .we(wr_fire && in_bank(paddr)),
        .waddr({bank_reg, paddr[`CBC_BANK_IDX]}),
        .wdata(pwdata[7:0]),
        .raddr({bank_reg, paddr[`CBC_BANK_IDX]}),
        .rdata(bank_rdata)
    );

    always_comb begin
        rd_mux = 32'h00000000;
        hit = 1'b1;
        if (paddr == `CBC_OFF_CMD) begin
            rd_mux = {28'h0000000, cmd_last_reg, cmd_kind_reg};
        end else if (paddr == `CBC_OFF_ADDR) begin
            rd_mux = {16'h0000, addr_reg};
        end else if (paddr == `CBC_OFF_WDATA) begin
            rd_mux = {24'h000000, wdata_reg};
        end else if (paddr == `CBC_OFF_STATUS) begin
            rd_mux = {8'h00, vector_reg, rdata_reg, 2'h0, bank_reg, at_bound_reg,
                      nmi_pend_reg, (st_reg == ST_REL), halted_reg, busy};
        end else if (paddr == `CBC_OFF_PCSP) begin
            rd_mux = {sp_reg, pc_reg};
        end else if (paddr == `CBC_OFF_IRM) begin
            rd_mux = {7'h00, ie_reg, 6'h00, im_reg, 1'b0, rcnt_reg, ireg_reg};
        end else if (in_bank(paddr)) begin
            rd_mux = {24'h000000, bank_rdata};
        end else begin
            hit = 1'b0;
        end
    end

    // One wait state on every access gives the bank array time to register its data.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= acc && !pready;
            pslverr <= acc && !pready && !hit;
            if (acc && !pready) begin
                prdata <= rd_mux;
            end
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_wait_held;
        (st_reg == ST_TW) && wait_lo;
    endsequence

    sequence s_m1_start;
        (st_reg == ST_T1) && is_m1kind(kind_reg);
    endsequence

    a_fetch_address: assert property (
        (st_reg == ST_T1 && kind_reg == K_FETCH) |-> address_out == pc_reg - 16'h0001)
        else $error("fetch address is not the previous counter value");
    a_port_high_zero: assert property (
        (!port_request_n && opcode_fetch_cycle_n) |-> address_out[15:8] == `CBC_PORT_HIGH)
        else $error("port cycle drives upper address lines");
    a_refresh_pairing: assert property (
        !refresh_cycle_n |-> !memory_access_request_n && rd_n && address_out[6:0] == rcnt_reg)
        else $error("refresh strobe without memory request or counter");
    a_fetch_indicator: assert property (
        s_m1_start |-> !opcode_fetch_cycle_n ##1 !opcode_fetch_cycle_n)
        else $error("opcode fetch indicator missing in first states");
    a_ack_pairing: assert property (
        (st_reg == ST_T2 && kind_reg == K_INTA)
            |-> !opcode_fetch_cycle_n && !port_request_n && memory_access_request_n)
        else $error("acknowledge lacks fetch indicator with port request");
    a_memory_access_request_address: assert property (
        !memory_access_request_n |-> addr_oe && ctrl_oe)
        else $error("memory request without driven address");
    a_write_data: assert property (
        !wr_n |-> data_oe && $stable(data_out))
        else $error("write strobe without stable driven data");
    a_halt_nop: assert property (
        ((st_reg == ST_T1) && (kind_reg == K_HALT)) |-> !halt_n && !rd_n && !opcode_fetch_cycle_n)
        else $error("halt loop cycle without halt output");
    a_wait_hold: assert property (
        s_wait_held |=> (st_reg == ST_TW) && refresh_cycle_n)
        else $error("left wait state while wait held");
    a_int_accept: assert property (
        go_int |=> (st_reg == ST_T1) && (kind_reg == K_INTA) && !ie_reg ##1 !port_request_n)
        else $error("maskable acceptance sequence wrong");
    a_nmi_latch: assert property (
        nmi_edge |=> nmi_pend_reg || (nmi_step_reg == `CBC_STEP_FIRST))
        else $error("non-maskable edge lost");
    a_nmi_restart: assert property (
        (mc_last && nmi_step_reg == `CBC_STEP_RUN2) |=> pc_reg == `CBC_NMI_ADDR)
        else $error("counter not at restart address after push");
    a_bus_release: assert property (
        (mc_last && bus_takeover_request_lo) |=> !bus_released_n && !addr_oe && !data_oe && !ctrl_oe)
        else $error("buses not floated after takeover request");
endmodule

// ===== rtl/cbc_consts.svh
`ifndef CBC_CONSTS_SVH
`define CBC_CONSTS_SVH

`define CBC_OFF_CMD 12'h000
`define CBC_OFF_ADDR 12'h004
`define CBC_OFF_WDATA 12'h008
`define CBC_OFF_STATUS 12'h00C
`define CBC_OFF_PCSP 12'h010
`define CBC_OFF_IRM 12'h014
`define CBC_OFF_BANK_LO 12'h040
`define CBC_OFF_BANK_HI 12'h05C

`define CBC_CMD_KIND 2:0
`define CBC_CMD_LAST 3
`define CBC_ADDR_F 15:0
`define CBC_WDATA_F 7:0
`define CBC_PCSP_PC 15:0
`define CBC_PCSP_SP 31:16
`define CBC_IRM_I 7:0
`define CBC_IRM_R 14:8
`define CBC_IRM_IM 17:16
`define CBC_IRM_IE 24
`define CBC_BANK_IDX 4:2

`define CBC_PC_RESET 16'h0000
`define CBC_SP_RESET 16'h0000
`define CBC_NMI_ADDR 16'h0066
`define CBC_IREG_RESET 8'h00
`define CBC_RCNT_RESET 7'h00
`define CBC_IM_RESET 2'h0
`define CBC_PORT_HIGH 8'h00
`define CBC_STEP_FIRST 2'h1
`define CBC_STEP_SECOND 2'h2
`define CBC_STEP_RUN2 2'h3

`endif

// ===== rtl/cbc_pkg.sv
package cbc_pkg;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_T1 = 7'h02,
        ST_T2 = 7'h04,
        ST_TW = 7'h08,
        ST_T3 = 7'h10,
        ST_T4 = 7'h20,
        ST_REL = 7'h40
    } cbc_state_t;

    typedef enum logic [2:0] {
        K_FETCH = 3'h0,
        K_MRD = 3'h1,
        K_MWR = 3'h2,
        K_PRD = 3'h3,
        K_PWR = 3'h4,
        K_INTA = 3'h5,
        K_HALT = 3'h6,
        K_EXX = 3'h7
    } cbc_kind_t;

endpackage

// ===== rtl/cbc_regbank.sv
`timescale 1ns/100ps

// Two register banks share one array; the bank select is the top address bit.
module cbc_regbank #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input logic clk,
    input logic we,
    input logic [AW-1:0] waddr,
    input logic [WIDTH-1:0] wdata,
    input logic [AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [0:DEPTH-1];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        rdata <= mem[raddr];
    end
endmodule
